// [bench/cpsk_core_properties.sv]
// assertion checker bound to the compare-and-skip sequencer
`timescale 1ns/1ps
module cpsk_core_props
    import cpsk_pkg::*;
(
    input wire logic                         clk,              // clock
    input wire logic                         resetn,           // reset
    input wire cpsk_pkg::cpsk_quarter_t      quarter,          // phase
    input wire logic                         instr_valid,      // word valid
    input wire logic [cpsk_pkg::INSTR_W-1:0] instr_word,       // word
    input wire logic                         next_two_word,    // two-word next
    input wire cpsk_pkg::cpsk_ctx_t          ctx,              // context
    input wire logic [cpsk_pkg::DATA_W-1:0]  working_register, // working value
    input wire logic [cpsk_pkg::DATA_W-1:0]  mem_rd_data,      // read data
    input wire logic [cpsk_pkg::ADDR_W-1:0]  mem_addr,         // address
    input wire logic                         mem_rd_en,        // read strobe
    input wire logic                         mem_wr_en,        // write strobe
    input wire logic                         busy,             // busy
    input wire logic                         discard_fetch,    // discard
    input wire logic                         nop_cycle,        // idle cycle
    input wire logic                         skip_taken_q      // last skip
);
    logic [6:0]        op_q;
    logic              take;
    logic              skip_c;
    logic [DATA_W-1:0] f;
    logic [ADDR_W-1:0] exp_a;

    assign f = instr_word[FILE_HI:FILE_LO];
    assign take = quarter == CPSK_Q1 && instr_valid && !busy
                  && instr_word[OPC_HI:OPC_LO] inside {OPC_LESS, OPC_EQUAL, OPC_GREATER};
    assign skip_c = op_q == OPC_EQUAL ? mem_rd_data == working_register :
                    op_q == OPC_GREATER ? mem_rd_data > working_register :
                    mem_rd_data < working_register;
    always_comb begin
        if (instr_word[ABIT_POS])
            exp_a = {ctx.bank_select_register, f};
        else if (ctx.ext_set_en && f <= INDEXED_MAX)
            exp_a = ctx.index_base + ADDR_W'(f);
        else
            exp_a = {(f <= ACCESS_LOW_MAX) ? ACCESS_LOW_BANK : ACCESS_SFR_BANK, f};
    end
    always_ff @(posedge clk) begin
        if (take)
            op_q <= instr_word[OPC_HI:OPC_LO];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    read_address_a: assert property (
        take |=> mem_rd_en && mem_addr == $past(exp_a)) else $error("read or address wrong");
    busy_span_a: assert property (take |=> busy [*3]) else $error("busy dropped");
    decide_a: assert property (
        quarter == CPSK_Q3 && $past(mem_rd_en) |=> discard_fetch == $past(skip_c))
        else $error("skip decision wrong");
    one_word_a: assert property (
        discard_fetch && !next_two_word |=> nop_cycle [*4] ##1 !nop_cycle)
        else $error("one idle cycle expected");
    two_word_a: assert property (
        discard_fetch && next_two_word |=> nop_cycle [*8] ##1 !nop_cycle)
        else $error("two idle cycles expected");
    no_skip_a: assert property (
        quarter == CPSK_Q4 && busy && !nop_cycle && !discard_fetch
        |=> !nop_cycle && !busy && !skip_taken_q) else $error("idle without skip");
    discard_q4_a: assert property (
        discard_fetch |-> quarter == CPSK_Q4 && !nop_cycle && $past(mem_rd_en, 2))
        else $error("discard out of place");
    skip_flag_a: assert property ($rose(nop_cycle) |-> skip_taken_q)
        else $error("skip flag not set");
    no_write_a: assert property (!mem_wr_en) else $error("write strobe seen");
    read_q2_a: assert property (mem_rd_en |-> quarter == CPSK_Q2 && busy)
        else $error("read outside second quarter");
endmodule

// [bench/cpsk_mem_model.sv]
// data memory model answering the compare block's reads
`timescale 1ns/1ps
module cpsk_mem_model (
    input  wire logic       clk,        // core clock
    input  wire logic       mem_rd_en,  // read strobe
    input  wire logic [7:0] byte_val,   // byte held at the read address
    output logic      [7:0] mem_rd_data // read data
);
    logic rd_q;
    always_ff @(posedge clk) begin
        rd_q <= mem_rd_en;
    end
    // outside the read window the line carries no valid byte
    assign mem_rd_data = (mem_rd_en || rd_q) ? byte_val : ~byte_val;
endmodule

// [bench/tb.sv]
// self-checking bench for the compare-and-skip sequencer
`timescale 1ns/1ps
module tb;
    import cpsk_pkg::*;
    logic          clk = 1'b0;
    logic          resetn = 1'b0;
    cpsk_quarter_t quarter = CPSK_Q1;
    logic          instr_valid = 1'b0;
    logic [15:0]   instr_word = 16'h0000;
    logic          next_two_word = 1'b0;
    cpsk_ctx_t     ctx = '0;
    logic [7:0]    working_register = 8'h00;
    logic [7:0]    byte_val = 8'h00;
    logic [7:0]    mem_rd_data;
    logic [13:0]   mem_addr;
    logic          mem_rd_en, mem_wr_en, busy, discard_fetch, nop_cycle, skip_taken_q;
    logic [6:0]    ops [5] = '{OPC_LESS, OPC_EQUAL, OPC_GREATER, 7'h33, 7'h2F};
    int            skip_log [$];
    int            errors = 0;
    int            total_checks = 0;
    int            cycles = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) quarter <= cpsk_quarter_t'(quarter + 2'h1);
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            close_out();
        end
    end

    cpsk_core uut (.clk, .resetn, .quarter, .instr_valid, .instr_word, .next_two_word,
        .ctx, .working_register, .mem_rd_data, .mem_addr, .mem_rd_en, .mem_wr_en,
        .busy, .discard_fetch, .nop_cycle, .skip_taken_q);
    cpsk_mem_model mem (.clk, .mem_rd_en, .byte_val, .mem_rd_data);

    task automatic close_out();
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic run_op(input logic [6:0] opc, input logic a, input logic [7:0] f,
                          input logic [7:0] d, input logic [7:0] w, input logic two);
        cpsk_ctx_t cx;
        int        cmp, skip, nops, ea, n;
        cx = cpsk_ctx_t'(21'($urandom()));
        cmp = opc inside {OPC_LESS, OPC_EQUAL, OPC_GREATER};
        skip = cmp && (opc == OPC_EQUAL ? int'(d) == int'(w) :
                       opc == OPC_GREATER ? int'(d) > int'(w) : int'(d) < int'(w));
        nops = skip ? (two ? 8 : 4) : 0;
        if (a) ea = cx.bank_select_register * 256 + f;
        else if (cx.ext_set_en && f <= 95) ea = (cx.index_base + f) % 16384;
        else ea = (f <= 95 ? 0 : 15) * 256 + f;
        do @(posedge clk); while (quarter != CPSK_Q4);
        instr_valid <= 1'b1;
        instr_word <= {opc, a, f};
        ctx <= cx;
        working_register <= w;
        byte_val <= d;
        next_two_word <= two;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk_bit(mem_rd_en, cmp[0], "read strobe");
        chk_bit(busy, cmp[0], "busy in read quarter");
        if (cmp) chk_word(16'(mem_addr), 16'(ea), "address");
        repeat (2) @(posedge clk);
        #1;
        chk_bit(discard_fetch, skip[0], "discard");
        if (cmp) skip_log.push_back(skip);
        n = 0;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            instr_valid <= (i < nops);
            #1;
            if (nop_cycle === 1'b1) n++;
            if (i == 0) chk_bit(skip_taken_q, 1'(skip_log[$]), "skip flag");
            chk_bit(busy, 1'(i < nops), "busy in idle cycle");
            chk_bit(mem_rd_en, 1'b0, "refused read");
            chk_bit(mem_wr_en, 1'b0, "write strobe");
        end
        chk_word(16'(n), 16'(nops), "idle cycles");
    endtask

    initial begin
        logic [7:0] w;
        void'($urandom(80));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        run_op(OPC_GREATER, 1'b0, 8'h5F, 8'hFF, 8'h00, 1'b0);
        run_op(OPC_GREATER, 1'b1, 8'h60, 8'h7F, 8'h80, 1'b1);
        run_op(OPC_LESS, 1'b0, 8'h60, 8'h00, 8'hFF, 1'b1);
        run_op(OPC_LESS, 1'b1, 8'hFF, 8'h80, 8'h7F, 1'b0);
        run_op(OPC_EQUAL, 1'b0, 8'h00, 8'h80, 8'h80, 1'b1);
        for (int k = 0; k < 60; k++) begin
            w = 8'($urandom());
            run_op(ops[$urandom_range(4)], 1'($urandom()),
                   k[0] ? 8'($urandom_range(99, 92)) : 8'($urandom()),
                   ($urandom_range(2) == 0) ? w : 8'($urandom()), w, 1'($urandom()));
        end
        close_out();
    end
endmodule

bind cpsk_core cpsk_core_props props (.clk, .resetn, .quarter, .instr_valid, .instr_word,
    .next_two_word, .ctx, .working_register, .mem_rd_data, .mem_addr, .mem_rd_en,
    .mem_wr_en, .busy, .discard_fetch, .nop_cycle, .skip_taken_q);

// [hdl/cpsk_compare.sv]
// unsigned subtract-and-compare unit with registered skip decision
`timescale 1ns/1ps
module cpsk_compare
    import cpsk_pkg::*;
(
    input  wire logic                     clk,          // core clock
    input  wire logic                     resetn,       // sync reset, low active
    input  wire logic                     sample,       // capture compare result
    input  wire cpsk_pkg::cpsk_op_t       op,           // compare kind
    input  wire logic [cpsk_pkg::DATA_W-1:0] data_byte, // addressed data byte
    input  wire logic [cpsk_pkg::DATA_W-1:0] working_register, // working value
    output logic                          skip_q        // skip condition held
);
    import cpsk_pkg::*;

    logic [DATA_W:0] diff;
    logic            borrow;
    logic            zero;
    logic            skip_d;

    // data minus working value, both unsigned; borrow means data is smaller
    assign diff   = {1'b0, data_byte} - {1'b0, working_register};
    assign borrow = diff[DATA_W];
    assign zero   = (diff[DATA_W-1:0] == '0);

    always_comb begin
        case (op)
            CPSK_OP_EQUAL:   skip_d = zero;
            CPSK_OP_GREATER: skip_d = !borrow && !zero;
            CPSK_OP_LESS:    skip_d = borrow;
            default:         skip_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            skip_q <= 1'b0;
        end else if (sample) begin
            skip_q <= skip_d;
        end
    end

endmodule

// [hdl/cpsk_core.sv]
// execution sequencer for the unsigned compare-and-skip instructions
`timescale 1ns/1ps
module cpsk_core
    import cpsk_pkg::*;
(
    input  wire logic                         clk,              // core clock
    input  wire logic                         resetn,           // sync reset, low active
    input  wire cpsk_pkg::cpsk_quarter_t      quarter,          // current quarter phase
    input  wire logic                         instr_valid,      // instr_word is executable
    input  wire logic [cpsk_pkg::INSTR_W-1:0] instr_word,       // instruction to execute
    input  wire logic                         next_two_word,    // prefetched word is 2-word
    input  wire cpsk_pkg::cpsk_ctx_t          ctx,              // bank and mode context
    input  wire logic [cpsk_pkg::DATA_W-1:0]  working_register, // working register value
    input  wire logic [cpsk_pkg::DATA_W-1:0]  mem_rd_data,      // data memory read data
    output logic [cpsk_pkg::ADDR_W-1:0]       mem_addr,         // data memory address
    output logic                              mem_rd_en,        // read strobe, second quarter
    output logic                              mem_wr_en,        // write strobe, never set
    output logic                              busy,             // compare or idle cycle active
    output logic                              discard_fetch,    // drop prefetched word
    output logic                              nop_cycle,        // idle cycle in progress
    output logic                              skip_taken_q      // last compare skipped
);
    import cpsk_pkg::*;

    cpsk_state_t         state_q;
    cpsk_state_t         state_d;
    cpsk_decode_t        dec_q;
    cpsk_decode_t        dec_now;
    logic                hit_now;
    logic                two_word_q;
    logic [ADDR_W-1:0]   addr_q;
    logic                sample_cmp;
    logic                skip_q;
    logic                q1;
    logic                q4;
    logic                exec_q2;
    logic                exec_q3;
    logic                exec_q4;

    // opcode decode of the upper seven bits
    function automatic logic is_compare(input logic [INSTR_W-1:0] w);
        logic [6:0] opc;
        opc = w[OPC_HI:OPC_LO];
        return (opc == OPC_LESS) || (opc == OPC_EQUAL) || (opc == OPC_GREATER);
    endfunction

    function automatic cpsk_op_t op_of(input logic [INSTR_W-1:0] w);
        logic [6:0] opc;
        opc = w[OPC_HI:OPC_LO];
        case (opc)
            OPC_EQUAL:   op_of = CPSK_OP_EQUAL;
            OPC_GREATER: op_of = CPSK_OP_GREATER;
            OPC_LESS:    op_of = CPSK_OP_LESS;
            default:     op_of = CPSK_OP_LESS;
        endcase
    endfunction

    // access bank: ram below the split, special registers above it
    function automatic logic [BANK_W-1:0] access_bank(input logic [DATA_W-1:0] f);
        return (f <= ACCESS_LOW_MAX) ? ACCESS_LOW_BANK : ACCESS_SFR_BANK;
    endfunction

    // forms the 14-bit data address from the operand and context
    function automatic logic [ADDR_W-1:0] data_address(input cpsk_decode_t d,
                                                       input cpsk_ctx_t c);
        logic [ADDR_W-1:0] a;
        a = ADDR_RESET;
        if (d.bank_access) begin
            a = {c.bank_select_register, d.file_addr};
        end else if (c.ext_set_en && (d.file_addr <= INDEXED_MAX)) begin
            a = ADDR_W'(c.index_base + {{BANK_W{1'b0}}, d.file_addr});
        end else begin
            a = {access_bank(d.file_addr), d.file_addr};
        end
        return a;
    endfunction

    // true in the compare cycle during the given quarter
    function automatic logic exec_at(input cpsk_state_t s, input cpsk_quarter_t q,
                                     input cpsk_quarter_t want);
        return (s == CPSK_ST_EXEC) && (q == want);
    endfunction

    assign q1 = (quarter == CPSK_Q1);
    assign q4 = (quarter == CPSK_Q4);
    assign exec_q2 = exec_at(state_q, quarter, CPSK_Q2);
    assign exec_q3 = exec_at(state_q, quarter, CPSK_Q3);
    assign exec_q4 = exec_at(state_q, quarter, CPSK_Q4);

    // operand fields of the word now offered for execution
    always_comb begin
        dec_now.op          = op_of(instr_word);
        dec_now.bank_access = instr_word[ABIT_POS];
        dec_now.file_addr   = instr_word[FILE_HI:FILE_LO];
    end

    // a new compare is only accepted from idle at the first quarter
    assign hit_now = q1 && instr_valid && is_compare(instr_word) &&
                     (state_q == CPSK_ST_IDLE);

    // leaves idle at the first quarter, every other state at the fourth
    always_comb begin
        state_d = state_q;
        case (state_q)
            CPSK_ST_IDLE: begin
                if (hit_now) begin
                    state_d = CPSK_ST_EXEC;
                end
            end
            CPSK_ST_EXEC: begin
                if (q4) begin
                    state_d = skip_q ? CPSK_ST_SKIP1 : CPSK_ST_IDLE;
                end
            end
            CPSK_ST_SKIP1: begin
                if (q4) begin
                    state_d = (two_word_q == IDLE_TWO_WORD) ? CPSK_ST_SKIP2
                                                             : CPSK_ST_IDLE;
                end
            end
            CPSK_ST_SKIP2: begin
                if (q4) begin
                    state_d = CPSK_ST_IDLE;
                end
            end
            default: state_d = CPSK_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= CPSK_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // first quarter: latch operands and the data address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dec_q  <= '{op: CPSK_OP_LESS, bank_access: 1'b0, file_addr: FILE_RESET};
            addr_q <= ADDR_RESET;
        end else if (hit_now) begin
            dec_q  <= dec_now;
            addr_q <= data_address(dec_now, ctx);
        end
    end

    // size of the word to be skipped, taken when the decision is made
    always_ff @(posedge clk) begin
        if (!resetn) begin
            two_word_q <= IDLE_ONE_WORD;
        end else if (exec_q4) begin
            two_word_q <= next_two_word ? IDLE_TWO_WORD : IDLE_ONE_WORD;
        end
    end

    // result of the last compare, held until the next one
    always_ff @(posedge clk) begin
        if (!resetn) begin
            skip_taken_q <= 1'b0;
        end else if (exec_q4) begin
            skip_taken_q <= skip_q;
        end
    end

    // third quarter: process the byte read in the second quarter; the data byte
    // and working_register are read live here, so both must stand through it
    assign sample_cmp = exec_q3;

    cpsk_compare u_compare (
        .clk              (clk),
        .resetn           (resetn),
        .sample           (sample_cmp),
        .op               (dec_q.op),
        .data_byte        (mem_rd_data),
        .working_register (working_register),
        .skip_q           (skip_q)
    );

    assign mem_addr      = addr_q;
    // compares never write memory, flags or the working register
    assign mem_wr_en     = 1'b0;

    // strobes and cycle flags decoded from state, quarter and skip_q
    always_comb begin
        mem_rd_en     = 1'b0;
        discard_fetch = 1'b0;
        nop_cycle     = 1'b0;
        busy          = 1'b1;
        case (state_q)
            CPSK_ST_IDLE: begin
                busy = 1'b0;
            end
            CPSK_ST_EXEC: begin
                mem_rd_en     = exec_q2;
                discard_fetch = exec_q4 && skip_q;
            end
            CPSK_ST_SKIP1: begin
                nop_cycle = 1'b1;
            end
            CPSK_ST_SKIP2: begin
                nop_cycle = 1'b1;
            end
            default: begin
                busy = 1'b0;
            end
        endcase
    end

endmodule

// [hdl/cpsk_pkg.sv]
// shared constants and types for the compare-and-skip execution block
package cpsk_pkg;

    localparam int DATA_W   = 8;
    localparam int BANK_W   = 6;
    localparam int ADDR_W   = BANK_W + DATA_W;
    localparam int INSTR_W  = 16;

    // opcode field positions and values
    localparam int OPC_HI   = 15;
    localparam int OPC_LO   = 9;
    localparam int ABIT_POS = 8;
    localparam int FILE_HI  = 7;
    localparam int FILE_LO  = 0;
    localparam logic [6:0] OPC_LESS    = 7'h30;
    localparam logic [6:0] OPC_EQUAL   = 7'h31;
    localparam logic [6:0] OPC_GREATER = 7'h32;

    // access bank split: lower part is data ram, upper part is the sfr bank
    localparam logic [DATA_W-1:0] INDEXED_MAX = 8'h5F;
    localparam logic [DATA_W-1:0] ACCESS_LOW_MAX = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 6'h00;
    localparam logic [BANK_W-1:0] ACCESS_SFR_BANK = 6'h0F;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
    localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;

    // number of idle cycles after a taken skip, minus one
    localparam logic IDLE_ONE_WORD = 1'b0;
    localparam logic IDLE_TWO_WORD = 1'b1;

    // quarter phases of the instruction cycle, an input to the core sequencer
    typedef enum logic [1:0] {
        CPSK_Q1 = 2'h0,
        CPSK_Q2 = 2'h1,
        CPSK_Q3 = 2'h2,
        CPSK_Q4 = 2'h3
    } cpsk_quarter_t;

    typedef enum logic [1:0] {
        CPSK_OP_LESS    = 2'h0,
        CPSK_OP_EQUAL   = 2'h1,
        CPSK_OP_GREATER = 2'h2
    } cpsk_op_t;

    // gray-coded along idle -> exec -> skip1 -> skip2
    typedef enum logic [1:0] {
        CPSK_ST_IDLE  = 2'h0,
        CPSK_ST_EXEC  = 2'h1,
        CPSK_ST_SKIP1 = 2'h3,
        CPSK_ST_SKIP2 = 2'h2
    } cpsk_state_t;

    // operands taken from the fetched instruction word
    typedef struct packed {
        cpsk_op_t           op;
        logic               bank_access;
        logic [DATA_W-1:0]  file_addr;
    } cpsk_decode_t;

    // core context needed to form the data address
    typedef struct packed {
        logic               ext_set_en;
        logic [BANK_W-1:0]  bank_select_register;
        logic [ADDR_W-1:0]  index_base;
    } cpsk_ctx_t;

endpackage
